/* include/wsm_pkg.sv */
// Package for the watchdog and supply monitor block
package wsm_pkg;
	// Register word offsets (byte addresses)
	localparam logic [3:0] WSM_OFS_WDCTL   = 4'h0;
	localparam logic [3:0] WSM_OFS_REFRESH = 4'h4;
	localparam logic [3:0] WSM_OFS_PSMCTL  = 4'h8;
	localparam logic [3:0] WSM_OFS_IE2     = 4'hC;
	// Watchdog control fields
	localparam int WSM_WD_EN_BIT   = 0;
	localparam int WSM_WD_PRE_LSB  = 4;
	localparam int WSM_WD_PRE_W    = 3;
	localparam int WSM_WD_RSTF_BIT = 7;
	// Supply control fields
	localparam int WSM_PSM_EN_BIT   = 0;
	localparam int WSM_PSM_TRIP_LSB = 1;
	localparam int WSM_PSM_TRIP_W   = 3;
	localparam int WSM_PSM_FLAG_BIT = 5;
	localparam int WSM_PSM_LOW_BIT  = 6;
	localparam int WSM_IE2_PSM_BIT  = 1;
	// Reset values, refresh key and highest trip code
	localparam logic [7:0] WSM_WDCTL_RST  = 8'h01;
	localparam logic [7:0] WSM_PSMCTL_RST = 8'h00;
	localparam logic [7:0] WSM_IE2_RST    = 8'h00;
	localparam logic [7:0] WSM_REFRESH_KEY = 8'hA5;
	localparam logic [2:0] WSM_TRIP_MAX   = 3'h4;
	// Timing
	localparam int WSM_CLK_HZ     = 50_000_000;
	localparam int WSM_WD_MIN_MS  = 16;
	localparam int WSM_WD_MAX_MS  = 204;
	localparam int WSM_RECOVER_MS = 256;
	localparam int WSM_GLITCH_US  = 10;
	localparam int WSM_RST_PULSE  = 16;
	localparam longint WSM_CYC_PER_MS = WSM_CLK_HZ / 1000;
	localparam longint WSM_GLITCH_CYC = (longint'(WSM_GLITCH_US) * WSM_CLK_HZ) / 1_000_000;
	localparam longint WSM_RECOVER_CYC = longint'(WSM_RECOVER_MS) * WSM_CYC_PER_MS;

	typedef enum logic [1:0] {WSM_SUP_OK, WSM_SUP_LOW, WSM_SUP_RECOVER} wsm_sup_t;

	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [3:0] adr;
		logic [7:0] dat;
	} wsm_bus_req_t;
endpackage

/* verilog/wsm_top.sv */
// Watchdog timer and supply monitor with a classic Wishbone slave
// Operation
// - While enabled, the watchdog resets the system if not refreshed within the interval.
// - Writing zero to the watchdog enable bit disables the watchdog.
// - Prescale bits select the timeout from 16 ms to 204 ms.
// - The supply monitor raises its interrupt when either supply drops below the trip level.
// - Software picks one of five trip levels from 2.6 V to 4.6 V.
// - The supply flag holds until the supply stays above trip for at least 256 ms.
// - Comparator outputs are glitch filtered before they can raise the interrupt.
// - All watchdog and supply monitor settings are readable and writable registers.
// - The supply interrupt reaches the processor only while its enable bit is one.
module wsm_top
	import wsm_pkg::*;
#(
	parameter longint WD_MIN_CYC  = longint'(WSM_WD_MIN_MS) * WSM_CYC_PER_MS,
	parameter longint WD_MAX_CYC  = longint'(WSM_WD_MAX_MS) * WSM_CYC_PER_MS,
	parameter longint RECOVER_CYC = WSM_RECOVER_CYC,
	parameter longint GLITCH_CYC  = WSM_GLITCH_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       wb_cyc_i,
	input  wire logic       wb_stb_i,
	input  wire logic       wb_we_i,
	input  wire logic [3:0] wb_adr_i,
	input  wire logic [0:0] wb_sel_i,
	input  wire logic [7:0] wb_dat_i,
	output logic      [7:0] wb_dat_o,
	output logic            wb_ack_o,
	output logic            wb_err_o,
	input  wire logic       avdd_below_trip,
	input  wire logic       dvdd_below_trip,
	output logic      [2:0] supply_trip_sel,
	output logic            system_reset,
	output logic            supply_monitor_irq
);

	typedef struct packed {
		logic       ack;
		logic       err;
		logic [7:0] rdata;
		logic       wd_en;
		logic [2:0] wd_pre;
		logic       wd_rstf;
		logic [31:0] wd_cnt;
		logic [4:0]  rst_cnt;
		logic       psm_en;
		logic [2:0] trip;
		logic       ie_psm;
		logic       flag;
		wsm_sup_t   sup;
		logic [31:0] filt_cnt;
		logic [31:0] rec_cnt;
		logic       rst_out;
		logic       irq_out;
	} wsm_state_t;

	wsm_state_t st;
	wsm_state_t next_st;

	// Interval grows linearly across the eight prescale codes
	function automatic logic [31:0] wd_limit(input logic [2:0] pre);
		longint span;
		span = (WD_MAX_CYC - WD_MIN_CYC) * longint'(pre) / 7;
		return 32'(WD_MIN_CYC + span);
	endfunction

	function automatic logic [7:0] read_mux(input logic [3:0] adr, input wsm_state_t s);
		logic [7:0] v;
		v = 8'h00;
		case (adr)
			WSM_OFS_WDCTL: begin
				v[WSM_WD_EN_BIT] = s.wd_en;
				v[WSM_WD_PRE_LSB +: WSM_WD_PRE_W] = s.wd_pre;
				v[WSM_WD_RSTF_BIT] = s.wd_rstf;
			end
			WSM_OFS_PSMCTL: begin
				v[WSM_PSM_EN_BIT] = s.psm_en;
				v[WSM_PSM_TRIP_LSB +: WSM_PSM_TRIP_W] = s.trip;
				v[WSM_PSM_FLAG_BIT] = s.flag;
				v[WSM_PSM_LOW_BIT] = (s.sup == WSM_SUP_LOW);
			end
			WSM_OFS_IE2: v[WSM_IE2_PSM_BIT] = s.ie_psm;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Only the four word addresses exist; anything else answers with err
	function automatic logic is_mapped(input logic [3:0] adr);
		logic hit;
		hit = 1'b0;
		case (adr)
			WSM_OFS_WDCTL:   hit = 1'b1;
			WSM_OFS_REFRESH: hit = 1'b1;
			WSM_OFS_PSMCTL:  hit = 1'b1;
			WSM_OFS_IE2:     hit = 1'b1;
			default:         hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Saturating step, so a supply held low for minutes cannot wrap a count
	function automatic logic [31:0] count_up(input logic [31:0] v);
		logic [31:0] r;
		r = v;
		if (v != 32'hFFFF_FFFF) begin
			r = v + 32'h1;
		end
		return r;
	endfunction

	// Reset pulse first, then counting; the count is held at zero while off
	function automatic wsm_state_t wd_step(input wsm_state_t s);
		wsm_state_t n;
		logic       expired;
		n = s;
		expired = (s.wd_cnt >= wd_limit(s.wd_pre) - 32'h1);
		if (s.rst_cnt != 5'h00) begin
			n.rst_cnt = s.rst_cnt - 5'h01;
			n.wd_cnt  = 32'h0;
		end else if (!s.wd_en) begin
			n.wd_cnt = 32'h0;
		end else if (expired) begin
			n.rst_cnt = 5'(WSM_RST_PULSE);
			n.wd_rstf = 1'b1;
			n.wd_cnt  = 32'h0;
		end else begin
			n.wd_cnt = count_up(s.wd_cnt);
		end
		return n;
	endfunction

	// Supply monitor; the filter counts consecutive low samples
	// A dip during recovery needs no filtering: the flag is still set anyway
	function automatic wsm_state_t sup_step(input wsm_state_t s, input logic low);
		wsm_state_t n;
		logic       filtered;
		logic       recovered;
		n = s;
		filtered  = low && (s.filt_cnt >= 32'(GLITCH_CYC) - 32'h1);
		recovered = !low && (s.rec_cnt >= 32'(RECOVER_CYC) - 32'h1);
		if (!s.psm_en) begin
			n.sup      = WSM_SUP_OK;
			n.filt_cnt = 32'h0;
			n.rec_cnt  = 32'h0;
			n.flag     = 1'b0;
		end else begin
			n.filt_cnt = low ? count_up(s.filt_cnt) : 32'h0;
			case (s.sup)
				WSM_SUP_OK: begin
					if (filtered) begin
						n.sup  = WSM_SUP_LOW;
						n.flag = 1'b1;
					end
				end
				WSM_SUP_LOW: begin
					n.flag    = 1'b1;
					n.rec_cnt = 32'h0;
					if (!low) begin
						n.sup = WSM_SUP_RECOVER;
					end
				end
				WSM_SUP_RECOVER: begin
					n.flag = 1'b1;
					if (low) begin
						n.sup     = WSM_SUP_LOW;
						n.rec_cnt = 32'h0;
					end else if (recovered) begin
						n.sup  = WSM_SUP_OK;
						n.flag = 1'b0;
					end else begin
						n.rec_cnt = count_up(s.rec_cnt);
					end
				end
				default: begin
					n.sup  = WSM_SUP_OK;
					n.flag = 1'b0;
				end
			endcase
		end
		return n;
	endfunction

	// Timeout flag: a hardware set in the same cycle beats the software clear
	function automatic wsm_state_t write_wdctl(input wsm_state_t s, input logic [7:0] d,
		input logic hw_set);
		wsm_state_t n;
		n = s;
		n.wd_en  = d[WSM_WD_EN_BIT];
		n.wd_pre = d[WSM_WD_PRE_LSB +: WSM_WD_PRE_W];
		if (d[WSM_WD_RSTF_BIT] && !hw_set) begin
			n.wd_rstf = 1'b0;
		end
		return n;
	endfunction

	// Any value but the key is ignored, so a stray store cannot feed the dog
	function automatic wsm_state_t write_refresh(input wsm_state_t s, input logic [7:0] d);
		wsm_state_t n;
		n = s;
		if (d == WSM_REFRESH_KEY) begin
			n.wd_cnt = 32'h0;
		end
		return n;
	endfunction

	// Codes above the last level are dropped and the old level kept
	function automatic wsm_state_t write_psmctl(input wsm_state_t s, input logic [7:0] d);
		wsm_state_t n;
		logic [2:0] code;
		n = s;
		code = d[WSM_PSM_TRIP_LSB +: WSM_PSM_TRIP_W];
		n.psm_en = d[WSM_PSM_EN_BIT];
		if (code <= WSM_TRIP_MAX) begin
			n.trip = code;
		end
		return n;
	endfunction

	function automatic wsm_state_t write_ie2(input wsm_state_t s, input logic [7:0] d);
		wsm_state_t n;
		n = s;
		n.ie_psm = d[WSM_IE2_PSM_BIT];
		return n;
	endfunction

	logic       req;
	logic       wr;
	logic       mapped;
	logic       below;
	logic       hw_set;
	wsm_state_t wd_st;
	wsm_state_t sup_st;

	always_comb begin
		req     = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
		wr      = req && wb_we_i && wb_sel_i[0];
		mapped  = is_mapped(wb_adr_i);
		below   = avdd_below_trip || dvdd_below_trip;
		wd_st   = wd_step(st);
		sup_st  = sup_step(st, below);
		hw_set  = (wd_st.rst_cnt == 5'(WSM_RST_PULSE));
		next_st = st;

		// Each step owns its own fields, so they are merged field by field
		next_st.rst_cnt  = wd_st.rst_cnt;
		next_st.wd_cnt   = wd_st.wd_cnt;
		next_st.wd_rstf  = wd_st.wd_rstf;
		next_st.sup      = sup_st.sup;
		next_st.flag     = sup_st.flag;
		next_st.filt_cnt = sup_st.filt_cnt;
		next_st.rec_cnt  = sup_st.rec_cnt;

		// Bus answer one cycle after the request is taken
		next_st.ack = req && mapped;
		next_st.err = req && !mapped;
		if (req && !wb_we_i) begin
			next_st.rdata = read_mux(wb_adr_i, st);
		end

		// Writes go last; a refresh during a timeout cannot cancel the pulse
		if (wr && mapped) begin
			case (wb_adr_i)
				WSM_OFS_WDCTL:   next_st = write_wdctl(next_st, wb_dat_i, hw_set);
				WSM_OFS_REFRESH: next_st = write_refresh(next_st, wb_dat_i);
				WSM_OFS_PSMCTL:  next_st = write_psmctl(next_st, wb_dat_i);
				WSM_OFS_IE2:     next_st = write_ie2(next_st, wb_dat_i);
				default:         next_st = next_st;
			endcase
		end

		// Outputs registered so the reset line cannot glitch
		next_st.rst_out = (next_st.rst_cnt != 5'h00);
		next_st.irq_out = next_st.flag && next_st.ie_psm;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st          <= '0;
			st.wd_en    <= WSM_WDCTL_RST[WSM_WD_EN_BIT];
			st.psm_en   <= WSM_PSMCTL_RST[WSM_PSM_EN_BIT];
			st.ie_psm   <= WSM_IE2_RST[WSM_IE2_PSM_BIT];
			st.sup      <= WSM_SUP_OK;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		wb_ack_o           = st.ack;
		wb_err_o           = st.err;
		wb_dat_o           = st.rdata;
		supply_trip_sel    = st.trip;
		system_reset       = st.rst_out;
		supply_monitor_irq = st.irq_out;
	end

endmodule // wsm_top

/* sim/wsm_monitor.sv */
// Port checker for the watchdog and supply monitor
module wsm_monitor
	import wsm_pkg::*;
#(
	parameter longint WD_MIN_CYC  = 20,
	parameter longint RECOVER_CYC = 50,
	parameter longint GLITCH_CYC  = 4
) (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       wb_stb_i,
	input wire logic       wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	input wire logic       wb_ack_o,
	input wire logic       wb_err_o,
	input wire logic       avdd_below_trip,
	input wire logic       dvdd_below_trip,
	input wire logic [2:0] supply_trip_sel,
	input wire logic       system_reset,
	input wire logic       supply_monitor_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic   low;
	longint low_n;
	longint ok_n;
	longint wd_n;
	assign low = avdd_below_trip | dvdd_below_trip;
	// Counts since refresh request, one edge late, so bounds carry slack
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_n <= 0;
			ok_n <= 0;
			wd_n <= 0;
		end else begin
			low_n <= low ? low_n + 1 : 0;
			ok_n <= low ? 0 : ok_n + 1;
			wd_n <= (system_reset || (wb_stb_i && wb_we_i && wb_adr_i == WSM_OFS_REFRESH
				&& wb_dat_i == WSM_REFRESH_KEY)) ? 0 : wd_n + 1;
		end
	end
	sequence s_pulse;
		system_reset [*8] ##1 system_reset [*8] ##1 !system_reset;
	endsequence
	AST_ACK: assert property (wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
		else $error("bus request not answered");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ERR: assert property (wb_err_o |-> ($past(wb_adr_i) & 4'h3) != 4'h0)
		else $error("error on a mapped address");
	AST_PULSE: assert property ($rose(system_reset) |-> s_pulse)
		else $error("reset pulse length wrong");
	AST_WD_MIN: assert property ($rose(system_reset) |-> wd_n >= WD_MIN_CYC - 1)
		else $error("reset before shortest interval");
	AST_IRQ_RISE: assert property ($rose(supply_monitor_irq) |-> wb_ack_o || low_n >= GLITCH_CYC - 1)
		else $error("irq without filtered low supply");
	AST_IRQ_FALL: assert property ($fell(supply_monitor_irq) |-> wb_ack_o || ok_n >= RECOVER_CYC - 1)
		else $error("irq cleared before recovery time");
	AST_TRIP: assert property (supply_trip_sel <= WSM_TRIP_MAX)
		else $error("trip level out of range");
endmodule // wsm_monitor

bind wsm_top wsm_monitor #(.WD_MIN_CYC(WD_MIN_CYC), .RECOVER_CYC(RECOVER_CYC),
	.GLITCH_CYC(GLITCH_CYC)) u_mon (.*);

/* sim/tb_top.sv */
// Self-checking bench for the watchdog and supply monitor
module tb_top
	import wsm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam longint MINC = 20;
	localparam longint MAXC = 90;
	logic         core_clk = 1'b0;
	logic         sys_rst = 1'b1;
	wsm_bus_req_t req = '0;
	logic         avdd_below_trip = 1'b0;
	logic         dvdd_below_trip = 1'b0;
	logic [7:0]   wb_dat_o, rd;
	logic [2:0]   supply_trip_sel;
	logic         wb_ack_o, wb_err_o, system_reset, supply_monitor_irq, err;
	int           bad_count = 0;
	int           checks_done = 0;
	int           cycles = 0;
	int           seen = 0;
	int           c;
	longint       t;
	always #10 core_clk = ~core_clk;
	wsm_top #(.WD_MIN_CYC(MINC), .WD_MAX_CYC(MAXC), .RECOVER_CYC(50), .GLITCH_CYC(4)) u_dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
		.wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(1'b1), .wb_dat_i(req.dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.avdd_below_trip(avdd_below_trip), .dvdd_below_trip(dvdd_below_trip),
		.supply_trip_sel(supply_trip_sel), .system_reset(system_reset),
		.supply_monitor_irq(supply_monitor_irq));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// Request held until ack or err is sampled, then released for a cycle
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req <= '{1'b1, 1'b1, w, a, d};
		do @(posedge core_clk); while (!(wb_ack_o | wb_err_o));
		rd = wb_dat_o;
		err = wb_err_o;
		req <= '0;
	endtask
	task automatic wait_rst();
		for (c = 0; system_reset !== 1'b1 && c < 300; c++) @(posedge core_clk);
	endtask
	always @(posedge core_clk) begin
		cycles++;
		seen += int'(system_reset === 1'b1);
		if (cycles == 5000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		wb(0, WSM_OFS_WDCTL, 0); chk("wdctl", WSM_WDCTL_RST, rd);
		wb(0, WSM_OFS_PSMCTL, 0); chk("psmctl", WSM_PSMCTL_RST, rd);
		wb(0, WSM_OFS_IE2, 0); chk("ie2", WSM_IE2_RST, rd);
		wb(0, 4'h2, 0); chk("unmapped", 1, err);
		$display("reset values done");
		for (int p = 0; p < 8; p += 7) begin
			wb(1, WSM_OFS_WDCTL, 8'h01 | 8'(p << 4));
			wb(1, WSM_OFS_REFRESH, WSM_REFRESH_KEY);
			wait_rst();
			t = MINC + (MAXC - MINC) * p / 7;
			chk("timeout", 1, c > t - 5 && c < t + 3);
			repeat (20) @(posedge core_clk);
			wb(0, WSM_OFS_WDCTL, 0); chk("rst flag", 8'h81 | 8'(p << 4), rd);
		end
		wb(1, WSM_OFS_WDCTL, 8'h01);
		t = seen;
		repeat (8) begin
			wb(1, WSM_OFS_REFRESH, WSM_REFRESH_KEY);
			repeat (12) @(posedge core_clk);
		end
		chk("kept alive", 0, 8'(seen - t));
		wb(1, WSM_OFS_WDCTL, 8'h80);
		wb(0, WSM_OFS_WDCTL, 0); chk("wd off", 8'h00, rd);
		wait_rst(); chk("no reset", 0, system_reset);
		$display("watchdog done");
		for (int k = 0; k < 5; k++) begin
			wb(1, WSM_OFS_PSMCTL, 8'(k * 2 + 1));
			chk("trip", 8'(k), supply_trip_sel);
		end
		// Code 5 is out of range, the last level must stay
		wb(1, WSM_OFS_PSMCTL, 8'h0B);
		wb(0, WSM_OFS_PSMCTL, 0); chk("psm ctl", 8'h09, rd);
		wb(1, WSM_OFS_IE2, 8'h02);
		wb(0, WSM_OFS_IE2, 0); chk("ie2 set", 8'h02, rd);
		avdd_below_trip <= 1'b1;
		repeat (2) @(posedge core_clk);
		avdd_below_trip <= 1'b0;
		repeat (10) @(posedge core_clk); chk("glitch", 0, supply_monitor_irq);
		dvdd_below_trip <= 1'b1;
		repeat (20) @(posedge core_clk); chk("irq low", 1, supply_monitor_irq);
		dvdd_below_trip <= 1'b0;
		repeat (30) @(posedge core_clk); chk("irq hold", 1, supply_monitor_irq);
		repeat (40) @(posedge core_clk); chk("irq clear", 0, supply_monitor_irq);
		avdd_below_trip <= 1'b1;
		repeat (20) @(posedge core_clk);
		wb(1, WSM_OFS_IE2, 8'h00); chk("irq masked", 0, supply_monitor_irq);
		wb(0, WSM_OFS_PSMCTL, 0); chk("flag", 1, rd[WSM_PSM_FLAG_BIT]);
		$display("supply monitor done");
		give_verdict();
	end
endmodule // tb_top
